// ==== design/cspm_pkg.sv ====
// Package: constants, register map and helpers for the clock/power unit
`default_nettype none
package cspm_pkg;
  // Clock rate and slow RC stand-in
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned SLOW_RC_HZ = 16_000;
  localparam int unsigned SLOW_DIV = CLK_HZ / SLOW_RC_HZ;
  localparam logic [11:0] SLOW_DIV_M1 = 12'(SLOW_DIV - 1);

  // Sequencer counts in oscillator periods
  localparam logic [17:0] CFG_FAST_DEF = 18'h20000;
  localparam logic [3:0] CFG_SLOW = 4'h8;
  localparam logic [17:0] WARM_FAST_LONG = 18'h00800;
  localparam logic [17:0] WARM_FAST_SHORT = 18'h00040;
  localparam logic [3:0] WARM_SLOW = 4'h5;

  // Register byte offsets
  localparam logic [7:0] OFS_MEM_WAIT = 8'h00;
  localparam logic [7:0] OFS_CPU_DIV = 8'h04;
  localparam logic [7:0] OFS_CLK_APPLY = 8'h08;
  localparam logic [7:0] OFS_PWR_CTRL = 8'h0c;
  localparam logic [7:0] OFS_P1_WAKE = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // Reset values and the apply key
  localparam logic [7:0] RST_MEM_WAIT = 8'h71;
  localparam logic [2:0] RST_CPU_DIV = 3'h7;
  localparam logic [7:0] RST_PWR_CTRL = 8'h08;
  localparam logic [7:0] RST_P1_WAKE = 8'h00;
  localparam logic [7:0] APPLY_KEY = 8'h69;

  // Field positions
  localparam int unsigned PC_LIGHT = 0;
  localparam int unsigned PC_DEEP = 1;
  localparam int unsigned PC_FLAG = 2;
  localparam int unsigned PC_MOVX = 3;
  localparam int unsigned PC_SRD = 7;
  localparam int unsigned MW_FETCH_LSB = 4;
  localparam int unsigned MW_XWR = 3;
  localparam int unsigned MW_XRD_LSB = 0;

  // Clock source options
  typedef enum logic [2:0] {
    OPT_RC = 3'h0,
    OPT_RC_RTC = 3'h1,
    OPT_XTAL_HI = 3'h2,
    OPT_XTAL_LO = 3'h3,
    OPT_EXT_CLK = 3'h4
  } cspm_opt_e;

  // Sequencer states
  typedef enum logic [5:0] {
    ST_CFG = 6'h01,
    ST_WARM = 6'h02,
    ST_RUN = 6'h04,
    ST_LIGHT = 6'h08,
    ST_DEEP = 6'h10,
    ST_WAKE = 6'h20
  } cspm_state_e;

  // Divider reload: fosc / 128 for code 0 up to fosc / 1 for code 7
  function automatic logic [6:0] cspm_div_reload(input logic [2:0] sel);
    cspm_div_reload = 7'((8'h80 >> sel) - 8'h01);
  endfunction : cspm_div_reload
endpackage : cspm_pkg
`default_nettype wire

// ==== design/cspm_warm_timer.sv ====
// Two-stage warm-up counter: fast periods first, then slow RC ticks
`timescale 1ns/1ps
`default_nettype none
module cspm_warm_timer (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic start,
  input wire logic [17:0] fast_n,
  input wire logic [3:0] slow_n,
  input wire logic slow_tick,
  // Result
  output logic done
);
  logic [17:0] fast_q;
  logic [3:0] slow_q;
  logic busy_q;

  // Load on start; fast count runs every cycle, slow count on RC ticks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fast_q <= 18'h0;
      slow_q <= 4'h0;
      busy_q <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        fast_q <= fast_n;
        slow_q <= slow_n;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (fast_q != 18'h0) begin
          fast_q <= fast_q - 18'h1;
        end else if (slow_q != 4'h0) begin
          if (slow_tick) begin
            slow_q <= slow_q - 4'h1;
          end
        end else begin
          busy_q <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule : cspm_warm_timer
`default_nettype wire

// ==== design/cspm_cpu_div.sv ====
// CPU clock enable divider, fosc / 128 .. fosc / 1
`timescale 1ns/1ps
`default_nettype none
module cspm_cpu_div (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic enable,
  input wire logic [2:0] sel,
  // Output pulse
  output logic tick
);
  logic [6:0] cnt_q;

  // Count down to zero, pulse, reload from the applied ratio
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 7'h0;
      tick <= 1'b0;
    end else if (!enable) begin
      cnt_q <= 7'h0;
      tick <= 1'b0;
    end else if (cnt_q == 7'h0) begin
      cnt_q <= cspm_pkg::cspm_div_reload(sel);
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q - 7'h1;
      tick <= 1'b0;
    end
  end
endmodule : cspm_cpu_div
`default_nettype wire

// ==== design/cspm_top.sv ====
// Clock source and power mode unit with AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module cspm_top #(
  parameter logic [17:0] CFG_FAST_CYCLES = cspm_pkg::CFG_FAST_DEF
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Power-on option strap
  input wire logic [2:0] clk_option,
  // Oscillator pins and their GPIO owners
  input wire logic osc_input_pin_in,
  output logic osc_input_pin_out,
  output logic osc_input_pin_oe,
  input wire logic osc_output_pin_in,
  output logic osc_output_pin_out,
  output logic osc_output_pin_oe,
  input wire logic in_gpio_out,
  input wire logic in_gpio_oe,
  input wire logic out_gpio_out,
  input wire logic out_gpio_oe,
  // Wake sources
  input wire logic [7:0] port0_in,
  input wire logic [7:0] port1_in,
  input wire logic irq_pending,
  // Program fetch handshake
  input wire logic fetch_start,
  output logic fetch_done,
  // Clock and mode outputs
  output logic cpu_clk_en,
  output logic periph_run,
  output logic osc_run,
  output logic xtal_drive_en,
  output logic rtc_tick,
  output logic [2:0] program_fetch_wait,
  output logic xram_write_extra,
  output logic [2:0] xram_read_wait,
  output logic movx_high_byte_select,
  output logic serial_rate_double
);
  cspm_pkg::cspm_state_e state_q;
  logic [2:0] opt_q;
  logic opt_taken_q;
  logic [7:0] mem_wait_q;
  logic [2:0] cpu_div_q;
  logic [2:0] div_applied_q;
  logic [7:0] pwr_ctrl_q;
  logic [7:0] p1_wake_q;
  logic [11:0] slow_cnt_q;
  logic slow_tick_q;
  logic start_q;
  logic warm_done;
  logic div_tick;
  logic [7:0] p0_prev_q;
  logic [7:0] p1_prev_q;
  logic in_pin_prev_q;
  logic wr_pend_q;
  logic rd_pend_q;
  logic [7:0] addr_q;
  logic [2:0] fetch_cnt_q;
  logic fetch_busy_q;
  logic pin_change;
  logic addr_ok;
  logic wr_cmt;
  logic rc_src;
  logic xtal_src;
  logic [17:0] tmr_fast;
  logic [3:0] tmr_slow;
  logic [7:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////
  // Option decode and strap capture

  assign rc_src = (opt_q == 3'(cspm_pkg::OPT_RC))
    || (opt_q == 3'(cspm_pkg::OPT_RC_RTC));
  assign xtal_src = (opt_q == 3'(cspm_pkg::OPT_RC_RTC))
    || (opt_q == 3'(cspm_pkg::OPT_XTAL_HI))
    || (opt_q == 3'(cspm_pkg::OPT_XTAL_LO));

  // Strap is sampled after release, never under the async reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      opt_q <= 3'h0;
      opt_taken_q <= 1'b0;
    end else if (!opt_taken_q) begin
      opt_q <= clk_option;
      opt_taken_q <= 1'b1;
    end
  end

  // Slow RC stand-in: enable pulse from a divider of hclk
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slow_cnt_q <= 12'h0;
      slow_tick_q <= 1'b0;
    end else if (slow_cnt_q == cspm_pkg::SLOW_DIV_M1) begin
      slow_cnt_q <= 12'h0;
      slow_tick_q <= 1'b1;
    end else begin
      slow_cnt_q <= slow_cnt_q + 12'h1;
      slow_tick_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Startup and sleep sequencer

  // Wake detect: port 0 always armed, port 1 per enable bit
  assign pin_change = (|(port0_in ^ p0_prev_q))
    || (|((port1_in ^ p1_prev_q) & p1_wake_q));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      p0_prev_q <= 8'h0;
      p1_prev_q <= 8'h0;
    end else begin
      p0_prev_q <= port0_in;
      p1_prev_q <= port1_in;
    end
  end

  // Counts fed to the warm-up timer; it loads one edge after the state moves
  always_comb begin
    tmr_fast = cspm_pkg::WARM_FAST_LONG;
    tmr_slow = cspm_pkg::WARM_SLOW;
    if (state_q == cspm_pkg::ST_CFG) begin
      tmr_fast = CFG_FAST_CYCLES;
      tmr_slow = cspm_pkg::CFG_SLOW;
    end else if (state_q == cspm_pkg::ST_WAKE && rc_src) begin
      tmr_fast = cspm_pkg::WARM_FAST_SHORT;
    end
  end

  cspm_warm_timer u_warm (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(start_q),
    .fast_n(tmr_fast),
    .slow_n(tmr_slow),
    .slow_tick(slow_tick_q),
    .done(warm_done)
  );

  // Mode state; light sleep keeps the oscillator so it resumes at once
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= cspm_pkg::ST_CFG;
      start_q <= 1'b1;
    end else begin
      start_q <= 1'b0;
      unique case (state_q)
        cspm_pkg::ST_CFG: begin
          if (warm_done) begin
            state_q <= cspm_pkg::ST_WARM;
            start_q <= 1'b1;
          end
        end
        cspm_pkg::ST_WARM: begin
          if (warm_done) begin
            state_q <= cspm_pkg::ST_RUN;
          end
        end
        cspm_pkg::ST_RUN: begin
          if (pwr_ctrl_q[cspm_pkg::PC_DEEP]) begin
            state_q <= cspm_pkg::ST_DEEP;
          end else if (pwr_ctrl_q[cspm_pkg::PC_LIGHT]) begin
            state_q <= cspm_pkg::ST_LIGHT;
          end
        end
        cspm_pkg::ST_LIGHT: begin
          if (pin_change || irq_pending) begin
            state_q <= cspm_pkg::ST_RUN;
          end
        end
        cspm_pkg::ST_DEEP: begin
          if (pin_change) begin
            state_q <= cspm_pkg::ST_WAKE;
            start_q <= 1'b1;
          end
        end
        cspm_pkg::ST_WAKE: begin
          if (warm_done) begin
            state_q <= cspm_pkg::ST_RUN;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // CPU clock, fetch wait and mode outputs

  cspm_cpu_div u_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .enable(state_q == cspm_pkg::ST_RUN),
    .sel(div_applied_q),
    .tick(div_tick)
  );

  // All outputs registered; deep sleep drops every clock enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_clk_en <= 1'b0;
      periph_run <= 1'b0;
      osc_run <= 1'b1;
      xtal_drive_en <= 1'b0;
    end else begin
      cpu_clk_en <= div_tick && (state_q == cspm_pkg::ST_RUN);
      periph_run <= (state_q == cspm_pkg::ST_RUN)
        || (state_q == cspm_pkg::ST_LIGHT);
      osc_run <= (state_q != cspm_pkg::ST_DEEP);
      xtal_drive_en <= xtal_src && opt_taken_q
        && (state_q != cspm_pkg::ST_DEEP);
    end
  end

  // Fetch wait: done follows start by the field value plus two cycles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fetch_cnt_q <= 3'h0;
      fetch_busy_q <= 1'b0;
      fetch_done <= 1'b0;
    end else begin
      fetch_done <= 1'b0;
      if (fetch_start && !fetch_busy_q) begin
        fetch_cnt_q <= mem_wait_q[cspm_pkg::MW_FETCH_LSB +: 3];
        fetch_busy_q <= 1'b1;
      end else if (fetch_busy_q) begin
        if (fetch_cnt_q == 3'h0) begin
          fetch_busy_q <= 1'b0;
          fetch_done <= 1'b1;
        end else begin
          fetch_cnt_q <= fetch_cnt_q - 3'h1;
        end
      end
    end
  end

  // Oscillator pin ownership per source option
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_input_pin_out <= 1'b0;
      osc_input_pin_oe <= 1'b0;
      osc_output_pin_out <= 1'b0;
      osc_output_pin_oe <= 1'b0;
      in_pin_prev_q <= 1'b0;
      rtc_tick <= 1'b0;
    end else begin
      in_pin_prev_q <= osc_input_pin_in;
      osc_input_pin_out <= in_gpio_out;
      osc_input_pin_oe <= in_gpio_oe && opt_taken_q
        && (opt_q == 3'(cspm_pkg::OPT_RC));
      osc_output_pin_out <= out_gpio_out;
      osc_output_pin_oe <= out_gpio_oe && opt_taken_q
        && ((opt_q == 3'(cspm_pkg::OPT_RC))
        || (opt_q == 3'(cspm_pkg::OPT_EXT_CLK)));
      rtc_tick <= (opt_q == 3'(cspm_pkg::OPT_RC_RTC))
        && osc_input_pin_in && !in_pin_prev_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: writes zero-wait, reads one wait state

  assign addr_ok = hsel && htrans[1] && hready;
  assign wr_cmt = wr_pend_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 8'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0;
    end else begin
      hresp <= 1'b0;
      wr_pend_q <= addr_ok && hwrite;
      if (addr_ok) begin
        addr_q <= {haddr[7:2], 2'b00};
      end
      if (addr_ok && !hwrite) begin
        rd_pend_q <= 1'b1;
        hreadyout <= 1'b0;
      end else if (rd_pend_q) begin
        rd_pend_q <= 1'b0;
        hreadyout <= 1'b1;
        hrdata <= {24'h0, rd_mux};
      end
    end
  end

  // Read mux: the command register reads zero, unmapped reads zero
  always_comb begin
    unique case (addr_q)
      cspm_pkg::OFS_MEM_WAIT: rd_mux = mem_wait_q;
      cspm_pkg::OFS_CPU_DIV: rd_mux = {5'h0, cpu_div_q};
      cspm_pkg::OFS_PWR_CTRL: rd_mux = pwr_ctrl_q;
      cspm_pkg::OFS_P1_WAKE: rd_mux = p1_wake_q;
      cspm_pkg::OFS_STATUS: rd_mux = {opt_q, div_applied_q,
        state_q == cspm_pkg::ST_RUN, state_q == cspm_pkg::ST_WAKE};
      default: rd_mux = 8'h0;
    endcase
  end

  // Register writes and the divider apply command
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_wait_q <= cspm_pkg::RST_MEM_WAIT;
      cpu_div_q <= cspm_pkg::RST_CPU_DIV;
      div_applied_q <= cspm_pkg::RST_CPU_DIV;
      p1_wake_q <= cspm_pkg::RST_P1_WAKE;
    end else if (wr_cmt) begin
      if (addr_q == cspm_pkg::OFS_MEM_WAIT) begin
        mem_wait_q <= {1'b0, hwdata[6:0]};
      end
      if (addr_q == cspm_pkg::OFS_CPU_DIV) begin
        cpu_div_q <= hwdata[2:0];
      end
      if (addr_q == cspm_pkg::OFS_CLK_APPLY
          && hwdata[7:0] == cspm_pkg::APPLY_KEY) begin
        div_applied_q <= cpu_div_q;
      end
      if (addr_q == cspm_pkg::OFS_P1_WAKE) begin
        p1_wake_q <= hwdata[7:0];
      end
    end
  end

  // Power control: hardware clears the sleep bits as the mode ends
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwr_ctrl_q <= cspm_pkg::RST_PWR_CTRL;
    end else if (wr_cmt && addr_q == cspm_pkg::OFS_PWR_CTRL) begin
      pwr_ctrl_q <= {hwdata[7], 3'h0, hwdata[3:0]};
    end else begin
      if (state_q == cspm_pkg::ST_LIGHT && (pin_change || irq_pending)) begin
        pwr_ctrl_q[cspm_pkg::PC_LIGHT] <= 1'b0;
      end
      if (state_q == cspm_pkg::ST_DEEP && pin_change) begin
        pwr_ctrl_q[cspm_pkg::PC_DEEP] <= 1'b0;
        pwr_ctrl_q[cspm_pkg::PC_LIGHT] <= 1'b0;
      end
    end
  end

  // Configuration fields passed to the core
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      program_fetch_wait <=
        cspm_pkg::RST_MEM_WAIT[cspm_pkg::MW_FETCH_LSB +: 3];
      xram_write_extra <= cspm_pkg::RST_MEM_WAIT[cspm_pkg::MW_XWR];
      xram_read_wait <= cspm_pkg::RST_MEM_WAIT[cspm_pkg::MW_XRD_LSB +: 3];
      movx_high_byte_select <= cspm_pkg::RST_PWR_CTRL[cspm_pkg::PC_MOVX];
      serial_rate_double <= cspm_pkg::RST_PWR_CTRL[cspm_pkg::PC_SRD];
    end else begin
      program_fetch_wait <= mem_wait_q[cspm_pkg::MW_FETCH_LSB +: 3];
      xram_write_extra <= mem_wait_q[cspm_pkg::MW_XWR];
      xram_read_wait <= mem_wait_q[cspm_pkg::MW_XRD_LSB +: 3];
      movx_high_byte_select <= pwr_ctrl_q[cspm_pkg::PC_MOVX];
      serial_rate_double <= pwr_ctrl_q[cspm_pkg::PC_SRD];
    end
  end

  // Unused inputs of the bus and pins are deliberately ignored
  logic unused_ok;
  assign unused_ok = ^{haddr[31:8], haddr[1:0], hsize, hwdata[31:8],
    osc_output_pin_in, pwr_ctrl_q[cspm_pkg::PC_FLAG]};
endmodule : cspm_top
`default_nettype wire

// ==== testbench/cspm_chk.sv ====
// Checker: bus, pin sharing, sleep and warm-up relations of the clock unit
`timescale 1ns/1ps
`default_nettype none
module cspm_chk (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // Option and pins
  input wire logic [2:0] clk_option,
  input wire logic in_gpio_oe,
  input wire logic out_gpio_oe,
  input wire logic osc_input_pin_oe,
  input wire logic osc_output_pin_oe,
  // Fetch and modes
  input wire logic fetch_start,
  input wire logic fetch_done,
  input wire logic [2:0] program_fetch_wait,
  input wire logic cpu_clk_en,
  input wire logic periph_run,
  input wire logic osc_run,
  input wire logic xtal_drive_en,
  input wire logic rtc_tick
);
  logic busy_q;
  logic [6:0] warm_q;
  ////////////////////////////////////////////////////////////////////////////
  // Fetch tracker: starts while busy are not taken
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) busy_q <= 1'b0;
    else if (fetch_done) busy_q <= 1'b0;
    else if (fetch_start) busy_q <= 1'b1;
  end
  // Cycles since the oscillator last restarted, saturating
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) warm_q <= 7'h00;
    else if (!osc_run) warm_q <= 7'h00;
    else if (warm_q != 7'h7f) warm_q <= warm_q + 7'h01;
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_fetch_taken;
    fetch_start && !busy_q;
  endsequence
  a_bus_okay: assert property (!hresp)
    else $error("bus response not OKAY");
  a_read_wait: assert property (hsel && htrans[1] && hready && !hwrite
    |=> !hreadyout ##1 hreadyout) else $error("read wait not one cycle");
  a_in_gpio: assert property (osc_input_pin_oe |-> $past(in_gpio_oe) &&
    clk_option == 3'h0) else $error("input pin driven outside plain RC");
  a_out_gpio: assert property (osc_output_pin_oe |-> $past(out_gpio_oe)
    && clk_option inside {3'h0, 3'h4}) else $error("output pin misdriven");
  a_xtal_drive: assert property (xtal_drive_en |-> osc_run &&
    clk_option inside {3'h1, 3'h2, 3'h3}) else $error("crystal drive wrong");
  a_rtc_source: assert property (rtc_tick |-> clk_option == 3'h1)
    else $error("real-time tick without real-time option");
  a_deep_stop: assert property (!osc_run |-> !periph_run && !cpu_clk_en)
    else $error("activity while oscillator stopped");
  a_light_gate: assert property (cpu_clk_en |-> periph_run)
    else $error("cpu enabled without peripherals");
  a_warm_cpu: assert property (cpu_clk_en |-> warm_q >= 7'h40)
    else $error("cpu enabled before warm-up");
  a_fetch_none: assert property (s_fetch_taken ##0
    program_fetch_wait == 3'h0 |-> ##1 !fetch_done ##1 fetch_done)
    else $error("fetch without wait not done in two cycles");
  a_fetch_three: assert property (s_fetch_taken ##0
    program_fetch_wait == 3'h3 |-> ##1 !fetch_done [*4] ##1 fetch_done)
    else $error("fetch with three waits not done in five cycles");
endmodule : cspm_chk
bind cspm_top cspm_chk u_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite,
  .hready, .hreadyout, .hresp, .clk_option, .in_gpio_oe, .out_gpio_oe,
  .osc_input_pin_oe, .osc_output_pin_oe, .fetch_start, .fetch_done,
  .program_fetch_wait, .cpu_clk_en, .periph_run, .osc_run, .xtal_drive_en,
  .rtc_tick);
`default_nettype wire

// ==== testbench/cspm_test.sv ====
// Testbench: registers, pin sharing, divider, sleep and wake of the unit
`timescale 1ns/1ps
`default_nettype none
module cspm_test;
  // Driven inputs, a few fixed for the whole run
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2, clk_option = 3'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic osc_input_pin_in = 1'b0, osc_output_pin_in = 1'b0;
  logic in_gpio_out = 1'b0, in_gpio_oe = 1'b1;
  logic out_gpio_out = 1'b0, out_gpio_oe = 1'b1;
  logic [7:0] port0_in = 8'h00, port1_in = 8'h00;
  logic irq_pending = 1'b0, fetch_start = 1'b0;
  // Observed outputs
  logic hreadyout, hresp, osc_input_pin_out, osc_input_pin_oe;
  logic osc_output_pin_out, osc_output_pin_oe, fetch_done, cpu_clk_en;
  logic periph_run, osc_run, xtal_drive_en, rtc_tick, xram_write_extra;
  logic movx_high_byte_select, serial_rate_double;
  logic [2:0] program_fetch_wait, xram_read_wait;
  logic [31:0] hrdata;
  // Rows: pin owner per option {in oe, out oe, crystal}; register cases
  logic [2:0] pin_exp [5] = '{3'h6, 3'h1, 3'h1, 3'h1, 3'h2};
  logic [31:0] rows [6] = '{32'h0071ff7f, 32'h0407ff07, 32'h08005500,
    32'h0c088c8c, 32'h1000a5a5, 32'h2000ff00};
  int errors = 0, check_count = 0, cyc = 0, cpu_n = 0, rtc_n = 0;
  int n, c, c0, t0;
  ////////////////////////////////////////////////////////////////////////////
  // Short config count keeps the start-up near 43k cycles
  cspm_top #(.CFG_FAST_CYCLES(18'h00010)) uut (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .clk_option, .osc_input_pin_in,
    .osc_input_pin_out, .osc_input_pin_oe, .osc_output_pin_in,
    .osc_output_pin_out, .osc_output_pin_oe, .in_gpio_out, .in_gpio_oe,
    .out_gpio_out, .out_gpio_oe, .port0_in, .port1_in, .irq_pending,
    .fetch_start, .fetch_done, .cpu_clk_en, .periph_run, .osc_run,
    .xtal_drive_en, .rtc_tick, .program_fetch_wait, .xram_write_extra,
    .xram_read_wait, .movx_high_byte_select, .serial_rate_double);
  // 50 MHz clock
  initial begin
    forever #10 hclk = ~hclk;
  end
  // Pulse counters; non-blocking so readers after an edge see old counts
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    cpu_n <= cpu_n + int'(cpu_clk_en === 1'b1);
    rtc_n <= rtc_n + int'(rtc_tick === 1'b1);
  end
  ////////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task end_sim;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  // One single transfer: address phase, then data phase until ready
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
           output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask : bus
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, {24'h000000, d}, q);
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk("reg_read", q, {24'h000000, e});
  endtask : rd
  // Counts cpu enables over k edges
  task cnt(input int k, output int r);
    int s;
    s = cpu_n;
    repeat (k) @(posedge hclk);
    r = cpu_n - s;
  endtask : cnt
  // Waits two edges so the wait field output has settled first
  task fetch(input int w);
    int k;
    repeat (2) @(posedge hclk);
    fetch_start <= 1'b1;
    @(posedge hclk);
    fetch_start <= 1'b0;
    for (k = 0; k < 20 && fetch_done !== 1'b1; k++) @(posedge hclk);
    chk("fetch_len", k, w + 2);
  endtask : fetch
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog well past the expected 62k cycles
  initial begin
    repeat (95000) @(posedge hclk);
    errors++;
    end_sim();
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge hclk);
    chk("reset_outs", {hreadyout, hresp, cpu_clk_en, periph_run, osc_run,
      program_fetch_wait, xram_read_wait, movx_high_byte_select},
      {5'h11, 3'h7, 3'h1, 1'h1});
    for (int i = 0; i < 5; i++) begin
      hresetn <= 1'b0;
      clk_option <= 3'(i);
      in_gpio_out <= i[0];
      out_gpio_out <= !i[0];
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (4) @(posedge hclk);
      chk("pin_mux", {osc_input_pin_oe, osc_output_pin_oe, xtal_drive_en,
        osc_input_pin_out, osc_output_pin_out}, {pin_exp[i], i[0], !i[0]});
    end
    hresetn <= 1'b0;
    clk_option <= 3'h1;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t0 = cyc;
    @(posedge hclk);
    for (int i = 0; i < 6; i++) begin
      rd(rows[i][31:24], rows[i][23:16]);
      wr(rows[i][31:24], rows[i][15:8]);
      rd(rows[i][31:24], rows[i][7:0]);
    end
    chk("field_outs", {program_fetch_wait, xram_write_extra, xram_read_wait,
      movx_high_byte_select, serial_rate_double}, {3'h7, 3'h7, 3'h7});
    c0 = rtc_n;
    repeat (4) begin
      osc_input_pin_in <= 1'b1;
      repeat (4) @(posedge hclk);
      osc_input_pin_in <= 1'b0;
      repeat (4) @(posedge hclk);
    end
    repeat (4) @(posedge hclk);
    chk("rtc_ticks", rtc_n - c0, 4);
    wr(8'h00, 8'h00);
    fetch(0);
    wr(8'h00, 8'h30);
    fetch(3);
    for (n = 0; n < 50000 && cpu_clk_en !== 1'b1; n++) @(posedge hclk);
    chk("startup_span", cyc - t0 >= 36000 && cyc - t0 <= 43000, 1);
    rd(8'h14, 8'h3e);
    wr(8'h04, 8'h02);
    wr(8'h08, 8'h12);
    cnt(128, c);
    chk("cpu_rate", c, 128);
    for (int s = 0; s < 8; s++) begin
      wr(8'h04, 8'(s));
      wr(8'h08, 8'h69);
      repeat (130) @(posedge hclk);
      cnt(128, c);
      chk("cpu_rate", c, 1 << s);
    end
    for (int k = 0; k < 2; k++) begin
      wr(8'h0c, 8'h8d);
      repeat (4) @(posedge hclk);
      cnt(64, c);
      chk("light_gate", {c[7:0], periph_run, osc_run, xtal_drive_en},
        {8'h00, 3'h7});
      rd(8'h0c, 8'h8d);
      if (k == 0) irq_pending <= 1'b1;
      else port0_in <= 8'h10;
      repeat (4) @(posedge hclk);
      irq_pending <= 1'b0;
      rd(8'h0c, 8'h8c);
      cnt(64, c);
      chk("light_resume", c, 64);
    end
    wr(8'h10, 8'h01);
    wr(8'h0c, 8'h8e);
    repeat (4) @(posedge hclk);
    chk("deep_stop", {osc_run, periph_run, xtal_drive_en}, 3'h0);
    irq_pending <= 1'b1;
    port1_in <= 8'h02;
    repeat (20) @(posedge hclk);
    chk("deep_hold", {osc_run, periph_run}, 2'h0);
    irq_pending <= 1'b0;
    port1_in <= 8'h03;
    for (n = 0; n < 20 && osc_run !== 1'b1; n++) @(posedge hclk);
    t0 = cyc;
    for (n = 0; n < 20000 && cpu_clk_en !== 1'b1; n++) @(posedge hclk);
    chk("deep_warm", cyc - t0 >= 12564 && cyc - t0 <= 15800, 1);
    rd(8'h0c, 8'h8c);
    rd(8'h00, 8'h30);
    rd(8'h10, 8'h01);
    end_sim();
  end
endmodule : cspm_test
`default_nettype wire
